/* File: include/merge_consts.svh */
// Purpose: Offsets, field positions, reset values for the load merge unit
// Assumes: Included by its bare name
// Notes: Byte addresses on a 32-bit AXI4-Lite bus
`ifndef MERGE_CONSTS_SVH
`define MERGE_CONSTS_SVH
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define MASK_OFFSET 8'h08
`define VIRTUAL_ADDRESS_OFFSET 8'h0C
`define CTRL_RESET 8'h00
`define EVENT_RESET 6'h00
`define CTRL_CPU_ENDIAN_BIT 0
`define CTRL_MEM_ENDIAN_BIT 1
`define CTRL_SWAP_BIT 2
`define CTRL_MODE64_BIT 3
`define CTRL_COP_EN_LSB 4
`define EV_TLB_REFILL_BIT 0
`define EV_TLB_INVALID_BIT 1
`define EV_BUS_BIT 2
`define EV_ADDR_BIT 3
`define EV_COP_BIT 4
`define EV_DONE_BIT 5
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: include/merge_pkg.sv */
// Purpose: Types shared by the load merge unit
// Assumes: Nothing
// Notes: Structs carry request, memory access and memory answer
package merge_pkg;
	typedef enum logic [1:0] {
		OP_LEFT  = 2'b00,
		OP_RIGHT = 2'b01,
		OP_COP   = 2'b10
	} load_op_type;
	typedef enum logic [2:0] {
		EXC_NONE         = 3'b000,
		EXC_TLB_REFILL   = 3'b001,
		EXC_TLB_INVALID  = 3'b010,
		EXC_BUS          = 3'b011,
		EXC_ADDR         = 3'b100,
		EXC_ALIGN        = 3'b101,
		EXC_COP_UNUSABLE = 3'b110
	} exc_code_type;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_MEM  = 1'b1
	} state_type;
	typedef struct packed {
		load_op_type op;
		logic [1:0]  cop_sel;
		logic [4:0]  dest;
		logic [15:0] offset;
		logic [63:0] base;
		logic [63:0] old_value;
	} load_req_type;
	typedef struct packed {
		logic [63:0] virtual_address;
		logic [1:0]  access_type;
		logic [2:0]  offset;
	} mem_req_type;
	typedef struct packed {
		exc_code_type fault;
		logic [63:0]  data;
	} mem_rsp_type;
endpackage

/* File: logic/word_merge.sv */
// Purpose: Merges loaded bytes into the old register value
// Assumes: Byte index and word select already corrected for endianness
// Notes: Purely combinational
`timescale 1ns/100ps
module word_merge (
	// Operation
	input  wire merge_pkg::load_op_type op,
	input  wire logic [1:0]             byte_index,
	input  wire logic                   word_sel,
	input  wire logic                   mode64,
	// Data
	input  wire logic [63:0]            mem_data,
	input  wire logic [63:0]            old_value,
	output logic      [63:0]            merged
);
	import merge_pkg::*;

	always_comb begin
		logic [31:0] mem_word;
		logic [31:0] keep_mask;
		logic [31:0] temp;
		logic [4:0]  shift;
		mem_word = word_sel ? mem_data[63:32] : mem_data[31:0];
		shift = 5'h00;
		keep_mask = 32'h0000_0000;
		temp = mem_word;
		merged = {32'h0000_0000, mem_word};
		if (op == OP_LEFT) begin
			// Addressed byte lands in the top byte, lower bytes kept
			shift = {~byte_index, 3'b000}; // RULE4
			keep_mask = ~(32'hFFFF_FFFF << shift);
			temp = (mem_word << shift) | (old_value[31:0] & keep_mask); // RULE4
			merged = {mode64 ? {32{temp[31]}} : old_value[63:32], temp}; // RULE5
		end else if (op == OP_RIGHT) begin
			// Addressed byte lands in the bottom byte, upper bytes kept
			shift = {byte_index, 3'b000}; // RULE6
			keep_mask = ~(32'hFFFF_FFFF >> shift);
			temp = (mem_word >> shift) | (old_value[31:0] & keep_mask); // RULE6
			if (mode64 && byte_index == 2'b00) begin
				merged = {{32{temp[31]}}, temp}; // RULE7
			end else begin
				merged = {old_value[63:32], temp}; // RULE7
			end
		end
	end
endmodule

/* File: logic/load_merge_unit.sv */
// Purpose: Partial-word left/right load and coprocessor word load datapath
// Assumes: Memory answers each access with one mem_rsp_valid pulse
// Notes: Registers on AXI4-Lite; one level interrupt
// What this block does
// RULE1: Left load address is base plus sign-extended 16-bit offset, any byte.
// RULE2: Right load address is base plus sign-extended 16-bit offset, any byte.
// RULE3: Only bytes of the aligned word holding the addressed byte are fetched.
// RULE4: Left load fills from the top byte down; lower register bytes kept.
// RULE5: Left load in 64-bit mode copies bit 31 into the upper half.
// RULE6: Right load fills from the bottom byte up; upper word bytes kept.
// RULE7: Right load sign-extends in 64-bit mode only when bit 31 was loaded.
// RULE8: Old destination value is forwarded from the immediately preceding load.
// RULE9: Partial-word loads never raise an alignment address error.
// RULE10: Translation refill, invalid, bus and address errors are reported.
// RULE11: Coprocessor load to a disabled coprocessor raises coprocessor unusable.
// RULE12: Byte index and word select are address bits XOR the CPU endian flag.
// RULE13: Memory gets access type 0 to 3 and a three-bit byte offset.
// RULE14: Merged value is written back once, like an ordinary word load.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "merge_consts.svh"
module load_merge_unit #(
	parameter int ADDR_WIDTH = 8
) (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	// AXI4-Lite slave
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Pipeline request
	input  wire logic                    req_valid,
	input  wire merge_pkg::load_req_type req,
	output logic                         req_ready,
	// Memory side
	output logic                         mem_req_valid,
	output merge_pkg::mem_req_type       mem_req,
	input  wire logic                    mem_rsp_valid,
	input  wire merge_pkg::mem_rsp_type  mem_rsp,
	// Results
	output logic                         wb_valid,
	output logic [4:0]                   wb_dest,
	output logic [63:0]                  wb_data,
	output logic                         cop_valid,
	output logic [1:0]                   cop_sel,
	output logic [31:0]                  cop_data,
	output logic                         exc_valid,
	output merge_pkg::exc_code_type      exc_code,
	output logic                         irq
);
	import merge_pkg::*;

	function automatic logic [2:0] reg_index(input logic [ADDR_WIDTH-1:0] a);
		case (a)
			ADDR_WIDTH'(`CTRL_OFFSET):   reg_index = 3'd0;
			ADDR_WIDTH'(`STATUS_OFFSET): reg_index = 3'd1;
			ADDR_WIDTH'(`MASK_OFFSET):   reg_index = 3'd2;
			ADDR_WIDTH'(`VIRTUAL_ADDRESS_OFFSET):  reg_index = 3'd3;
			default:                     reg_index = 3'd4;
		endcase
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Bus side state
	logic [7:0]            ctrl_reg, ctrl_next;
	logic [5:0]            status_reg, status_next;
	logic [5:0]            mask_reg, mask_next;
	logic                  irq_reg, irq_next;
	logic                  aw_full_reg, aw_full_next;
	logic                  w_full_reg, w_full_next;
	logic [ADDR_WIDTH-1:0] awaddr_reg, awaddr_next;
	logic [31:0]           wdata_reg, wdata_next;
	logic [3:0]            wstrb_reg, wstrb_next;
	logic                  awready_reg, awready_next;
	logic                  wready_reg, wready_next;
	logic                  bvalid_reg, bvalid_next;
	logic [1:0]            bresp_reg, bresp_next;
	logic                  arready_reg, arready_next;
	logic                  rvalid_reg, rvalid_next;
	logic [31:0]           rdata_reg, rdata_next;
	logic [1:0]            rresp_reg, rresp_next;
	// Pipeline side state
	state_type             state_reg, state_next;
	load_op_type           op_reg, op_next;
	logic [1:0]            csel_reg, csel_next;
	logic [4:0]            dest_reg, dest_next;
	logic [63:0]           old_reg, old_next;
	logic [1:0]            byte_reg, byte_next;
	logic                  word_reg, word_next;
	logic                  mode_reg, mode_next;
	logic                  ready_reg, ready_next;
	logic                  mreq_valid_reg, mreq_valid_next;
	mem_req_type           mreq_reg, mreq_next;
	logic                  wb_valid_reg, wb_valid_next;
	logic [4:0]            wb_dest_reg, wb_dest_next;
	logic [63:0]           wb_data_reg, wb_data_next;
	logic                  cop_valid_reg, cop_valid_next;
	logic [1:0]            cop_sel_reg, cop_sel_next;
	logic [31:0]           cop_data_reg, cop_data_next;
	logic                  exc_valid_reg, exc_valid_next;
	exc_code_type          exc_code_reg, exc_code_next;
	logic                  fwd_valid_reg, fwd_valid_next;
	logic [4:0]            fwd_dest_reg, fwd_dest_next;
	logic [63:0]           fwd_data_reg, fwd_data_next;
	logic [31:0]           last_virtual_address_reg, last_virtual_address_next;
	logic [5:0]            events;
	logic [63:0]           virtual_address;
	logic [63:0]           merged;
	logic                  take;

	assign take = req_valid && ready_reg;
	assign virtual_address = req.base + {{48{req.offset[15]}}, req.offset}; // RULE1 RULE2

	word_merge merge_inst (
		.op         (op_reg),
		.byte_index (byte_reg),
		.word_sel   (word_reg),
		.mode64     (mode_reg),
		.mem_data   (mem_rsp.data),
		.old_value  (old_reg),
		.merged     (merged)
	);

	always_comb begin
		logic [2:0] physical;
		logic       cpu_big;
		cpu_big = ctrl_reg[`CTRL_CPU_ENDIAN_BIT];
		physical = virtual_address[2:0] ^ {3{ctrl_reg[`CTRL_SWAP_BIT]}};
		state_next = state_reg;
		op_next = op_reg;
		csel_next = csel_reg;
		dest_next = dest_reg;
		old_next = old_reg;
		byte_next = byte_reg;
		word_next = word_reg;
		mode_next = mode_reg;
		ready_next = ready_reg;
		mreq_valid_next = 1'b0;
		mreq_next = mreq_reg;
		wb_valid_next = 1'b0;
		wb_dest_next = wb_dest_reg;
		wb_data_next = wb_data_reg;
		cop_valid_next = 1'b0;
		cop_sel_next = cop_sel_reg;
		cop_data_next = cop_data_reg;
		exc_valid_next = 1'b0;
		exc_code_next = exc_code_reg;
		fwd_valid_next = fwd_valid_reg;
		fwd_dest_next = fwd_dest_reg;
		fwd_data_next = fwd_data_reg;
		last_virtual_address_next = last_virtual_address_reg;
		events = `EVENT_RESET;
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					op_next = req.op;
					csel_next = req.cop_sel;
					dest_next = req.dest;
					mode_next = ctrl_reg[`CTRL_MODE64_BIT];
					byte_next = virtual_address[1:0] ^ {2{cpu_big}}; // RULE12
					word_next = virtual_address[2] ^ cpu_big; // RULE12
					last_virtual_address_next = virtual_address[31:0];
					fwd_valid_next = 1'b0;
					if (fwd_valid_reg && req.dest == fwd_dest_reg) begin
						old_next = fwd_data_reg; // RULE8
					end else begin
						old_next = req.old_value;
					end
					if (req.op == OP_COP && !ctrl_reg[`CTRL_COP_EN_LSB + req.cop_sel]) begin
						exc_valid_next = 1'b1; // RULE11
						exc_code_next = EXC_COP_UNUSABLE;
						events[`EV_COP_BIT] = 1'b1;
					end else if (req.op == OP_COP && virtual_address[1:0] != 2'b00) begin
						exc_valid_next = 1'b1;
						exc_code_next = EXC_ALIGN;
						events[`EV_ADDR_BIT] = 1'b1;
					end else begin
						// Partial loads skip the alignment check entirely
						mreq_valid_next = 1'b1; // RULE9
						mreq_next.virtual_address = virtual_address;
						if (req.op == OP_COP) begin
							mreq_next.access_type = 2'b11;
							mreq_next.offset = physical;
						end else begin
							mreq_next.access_type = virtual_address[1:0] ^ {2{cpu_big}}; // RULE13
							mreq_next.offset = {physical[2], 2'b00}; // RULE3 RULE13
						end
						ready_next = 1'b0;
						state_next = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (mem_rsp_valid) begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
					if (mem_rsp.fault != EXC_NONE) begin
						exc_valid_next = 1'b1; // RULE10
						exc_code_next = (mem_rsp.fault == EXC_ALIGN) ? EXC_ADDR : mem_rsp.fault;
						events[`EV_TLB_REFILL_BIT] = mem_rsp.fault == EXC_TLB_REFILL;
						events[`EV_TLB_INVALID_BIT] = mem_rsp.fault == EXC_TLB_INVALID;
						events[`EV_BUS_BIT] = mem_rsp.fault == EXC_BUS;
						events[`EV_ADDR_BIT] = mem_rsp.fault == EXC_ADDR
							|| mem_rsp.fault == EXC_ALIGN;
					end else if (op_reg == OP_COP) begin
						cop_valid_next = 1'b1;
						cop_sel_next = csel_reg;
						cop_data_next = merged[31:0];
						events[`EV_DONE_BIT] = 1'b1;
					end else begin
						wb_valid_next = 1'b1; // RULE14
						wb_dest_next = dest_reg;
						wb_data_next = merged;
						fwd_valid_next = 1'b1; // RULE8
						fwd_dest_next = dest_reg;
						fwd_data_next = merged;
						events[`EV_DONE_BIT] = 1'b1;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_LEFT;
			csel_reg <= 2'h0;
			dest_reg <= 5'h00;
			old_reg <= 64'h0000_0000_0000_0000;
			byte_reg <= 2'h0;
			word_reg <= 1'b0;
			mode_reg <= 1'b0;
			ready_reg <= 1'b1;
			mreq_valid_reg <= 1'b0;
			mreq_reg <= '0;
			wb_valid_reg <= 1'b0;
			wb_dest_reg <= 5'h00;
			wb_data_reg <= 64'h0000_0000_0000_0000;
			cop_valid_reg <= 1'b0;
			cop_sel_reg <= 2'h0;
			cop_data_reg <= 32'h0000_0000;
			exc_valid_reg <= 1'b0;
			exc_code_reg <= EXC_NONE;
			fwd_valid_reg <= 1'b0;
			fwd_dest_reg <= 5'h00;
			fwd_data_reg <= 64'h0000_0000_0000_0000;
			last_virtual_address_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			csel_reg <= csel_next;
			dest_reg <= dest_next;
			old_reg <= old_next;
			byte_reg <= byte_next;
			word_reg <= word_next;
			mode_reg <= mode_next;
			ready_reg <= ready_next;
			mreq_valid_reg <= mreq_valid_next;
			mreq_reg <= mreq_next;
			wb_valid_reg <= wb_valid_next;
			wb_dest_reg <= wb_dest_next;
			wb_data_reg <= wb_data_next;
			cop_valid_reg <= cop_valid_next;
			cop_sel_reg <= cop_sel_next;
			cop_data_reg <= cop_data_next;
			exc_valid_reg <= exc_valid_next;
			exc_code_reg <= exc_code_next;
			fwd_valid_reg <= fwd_valid_next;
			fwd_dest_reg <= fwd_dest_next;
			fwd_data_reg <= fwd_data_next;
			last_virtual_address_reg <= last_virtual_address_next;
		end
	end

	always_comb begin
		logic [31:0] m;
		logic        do_write;
		aw_full_next = aw_full_reg | (s_axi_awvalid & awready_reg);
		w_full_next = w_full_reg | (s_axi_wvalid & wready_reg);
		awaddr_next = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : awaddr_reg;
		wdata_next = (s_axi_wvalid & wready_reg) ? s_axi_wdata : wdata_reg;
		wstrb_next = (s_axi_wvalid & wready_reg) ? s_axi_wstrb : wstrb_reg;
		m = lane_mask(wstrb_next);
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		// Hardware events win over a same-cycle clear
		status_next = status_reg | events;
		bvalid_next = bvalid_reg & ~s_axi_bready;
		bresp_next = bresp_reg;
		do_write = aw_full_next & w_full_next & ~bvalid_reg;
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `RESP_OKAY;
			case (reg_index(awaddr_next))
				3'd0: ctrl_next = (ctrl_reg & ~m[7:0]) | (wdata_next[7:0] & m[7:0]);
				3'd1: status_next = (status_reg & ~(wdata_next[5:0] & m[5:0])) | events;
				3'd2: mask_next = (mask_reg & ~m[5:0]) | (wdata_next[5:0] & m[5:0]);
				3'd3: bresp_next = `RESP_OKAY;
				default: bresp_next = `RESP_SLVERR;
			endcase
		end
		awready_next = ~aw_full_next & ~bvalid_next;
		wready_next = ~w_full_next & ~bvalid_next;
		irq_next = |(status_next & mask_next);
		rvalid_next = rvalid_reg & ~s_axi_rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = `RESP_OKAY;
			case (reg_index(s_axi_araddr))
				3'd0: rdata_next = {24'h00_0000, ctrl_reg};
				3'd1: rdata_next = {26'h000_0000, status_reg};
				3'd2: rdata_next = {26'h000_0000, mask_reg};
				3'd3: rdata_next = last_virtual_address_reg;
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = `RESP_SLVERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= `CTRL_RESET;
			status_reg <= `EVENT_RESET;
			mask_reg <= `EVENT_RESET;
			irq_reg <= 1'b0;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
		end else begin
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= irq_next;
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign req_ready = ready_reg;
	assign mem_req_valid = mreq_valid_reg;
	assign mem_req = mreq_reg;
	assign wb_valid = wb_valid_reg;
	assign wb_dest = wb_dest_reg;
	assign wb_data = wb_data_reg;
	assign cop_valid = cop_valid_reg;
	assign cop_sel = cop_sel_reg;
	assign cop_data = cop_data_reg;
	assign exc_valid = exc_valid_reg;
	assign exc_code = exc_code_reg;
	assign irq = irq_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	left_addr_a: assert property (take && req.op == OP_LEFT |=> mreq_valid_reg // RULE1
		&& mreq_reg.virtual_address == $past(req.base) + {{48{$past(req.offset[15])}}, $past(req.offset)})
		else $error("left load address wrong");
	right_addr_a: assert property (take && req.op == OP_RIGHT |=> mreq_valid_reg // RULE2
		&& mreq_reg.virtual_address == $past(req.base) + {{48{$past(req.offset[15])}}, $past(req.offset)})
		else $error("right load address wrong");
	access_type_a: assert property (mreq_valid_reg && op_reg != OP_COP |-> // RULE12
		mreq_reg.access_type == byte_reg && byte_reg == (mreq_reg.virtual_address[1:0]
		^ {2{$past(ctrl_reg[`CTRL_CPU_ENDIAN_BIT])}}))
		else $error("access type not endian corrected byte index");
	lane_offset_a: assert property (mreq_valid_reg && op_reg != OP_COP |-> // RULE13
		mreq_reg.offset[1:0] == 2'b00) else $error("partial load offset not word aligned");
	bypass_old_a: assert property (take && fwd_valid_reg && req.dest == fwd_dest_reg // RULE8
		|=> old_reg == $past(fwd_data_reg)) else $error("forwarded value not used");
	no_align_a: assert property (exc_valid_reg && op_reg != OP_COP |-> // RULE9
		exc_code_reg != EXC_ALIGN) else $error("alignment error on partial load");
	fault_report_a: assert property (state_reg == ST_MEM && mem_rsp_valid // RULE10
		&& mem_rsp.fault != EXC_NONE |=> exc_valid_reg && !wb_valid_reg)
		else $error("memory fault not reported");
	cop_unusable_a: assert property (take && req.op == OP_COP // RULE11
		&& !ctrl_reg[`CTRL_COP_EN_LSB + req.cop_sel] |=> exc_valid_reg
		&& exc_code_reg == EXC_COP_UNUSABLE && !mreq_valid_reg)
		else $error("disabled coprocessor not flagged");
	left_keep_a: assert property (wb_valid_reg && op_reg == OP_LEFT && byte_reg == 2'd0 // RULE4
		|-> wb_data_reg[23:0] == old_reg[23:0]) else $error("left load lost low bytes");
	left_sext_a: assert property (wb_valid_reg && op_reg == OP_LEFT && mode_reg // RULE5
		|-> wb_data_reg[63:32] == {32{wb_data_reg[31]}}) else $error("left load not extended");
	right_keep_a: assert property (wb_valid_reg && op_reg == OP_RIGHT && byte_reg == 2'd3 // RULE6
		|-> wb_data_reg[31:8] == old_reg[31:8]) else $error("right load lost high bytes");
	right_upper_a: assert property (wb_valid_reg && op_reg == OP_RIGHT && mode_reg // RULE7
		&& byte_reg != 2'd0 |-> wb_data_reg[63:32] == old_reg[63:32])
		else $error("right load changed upper half");
	single_wb_a: assert property (mreq_valid_reg ##1 !mem_rsp_valid [*2] // RULE14
		|-> !wb_valid_reg) else $error("writeback without memory answer");
endmodule

/* File: testbench/mem_model.sv */
// Purpose: Memory side model that answers each access after a set delay
// Assumes: One access outstanding at a time
// Notes: Data lines show the inverse of the last value while no answer stands
`timescale 1ns/100ps
module mem_model #(
	parameter logic [63:0] DWORD = 64'h8899_aabb_ccdd_eeff
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// Access and test control
	input  wire logic                   mem_req_valid,
	input  wire merge_pkg::exc_code_type fault,
	input  wire logic [3:0]             delay,
	// Answer
	output logic                        mem_rsp_valid,
	output merge_pkg::mem_rsp_type      mem_rsp
);
	import merge_pkg::*;
	logic [4:0] cnt;
	always @(posedge clock) begin
		mem_rsp_valid <= 1'b0;
		mem_rsp.data <= ~mem_rsp.data;
		if (!rst_n) begin
			cnt <= 5'h00;
			mem_rsp <= '0;
		end else if (mem_req_valid) begin
			cnt <= {1'b0, delay} + 5'h01;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
		if (rst_n && cnt == 5'h01) begin
			mem_rsp_valid <= 1'b1;
			mem_rsp.data <= DWORD;
			mem_rsp.fault <= fault;
		end
	end
endmodule

/* File: testbench/load_merge_unit_tb.sv */
// Purpose: Self-checking bench for the partial-word load merge unit
// Assumes: Memory model answers with a programmable delay
// Notes: Expected merges are worked out here from byte positions
`timescale 1ns/100ps
`include "merge_consts.svh"
module load_merge_unit_tb;
	import merge_pkg::*;
	localparam logic [63:0] DW = 64'h8899_aabb_ccdd_eeff;
	localparam logic [63:0] BASE = 64'h0000_0000_0001_0008;
	localparam logic [63:0] OLD = 64'h0123_4567_89ab_cdef;
	logic clock = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, req_valid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, req_ready, mem_req_valid, mem_rsp_valid;
	logic wb_valid, cop_valid, exc_valid, irq;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, cop_data;
	logic [1:0] bresp, rresp, cop_sel;
	logic [3:0] delay = 4'h0;
	logic [4:0] wb_dest;
	logic [63:0] wb_data;
	load_req_type req = '0;
	mem_req_type mem_req;
	mem_rsp_type mem_rsp;
	exc_code_type fault = EXC_NONE, exc_code;
	int n_errors = 0, n_compared = 0;
	always #12.5 clock = ~clock;
	load_merge_unit #(.ADDR_WIDTH(8)) u_dut (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid),
		.mem_rsp(mem_rsp), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
		.cop_valid(cop_valid), .cop_sel(cop_sel), .cop_data(cop_data),
		.exc_valid(exc_valid), .exc_code(exc_code), .irq(irq));
	mem_model #(.DWORD(DW)) u_mem (.clock(clock), .rst_n(rst_n), .mem_req_valid(mem_req_valid),
		.fault(fault), .delay(delay), .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp));
	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Loops once past the handshake, so the next call never re-drives bready at once
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				check(bresp, er);
			end
		end while (bready);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				check({rresp, rdata}, {er, ed});
			end
		end while (rready);
	endtask
	function automatic logic [63:0] mrg(input logic left, input logic [2:0] va,
			input logic cpu, input logic m64, input logic [63:0] old);
		logic [1:0] b;
		logic [31:0] w, r;
		b = va[1:0] ^ {2{cpu}};
		w = (va[2] ^ cpu) ? DW[63:32] : DW[31:0];
		if (left)
			r = (w << (24 - 8 * b)) | (old[31:0] & ~(32'hffff_ffff << (24 - 8 * b)));
		else
			r = (w >> (8 * b)) | (old[31:0] & ~(32'hffff_ffff >> (8 * b)));
		return {(m64 && (left || b == 2'b00)) ? {32{r[31]}} : old[63:32], r};
	endfunction
	task automatic ld(input load_op_type op, input logic [15:0] off, input logic [4:0] dst,
			input logic [63:0] old, input int kind, input logic [63:0] ed, input logic [5:0] em);
		req <= '{op, 2'b01, dst, off, BASE, old};
		req_valid <= 1'b1;
		do @(posedge clock); while (!req_ready);
		req_valid <= 1'b0;
		while (!(wb_valid || cop_valid || exc_valid)) @(posedge clock);
		if (em[5]) check(mem_req.virtual_address, BASE + {{48{off[15]}}, off});
		if (em[5]) check({mem_req.access_type, mem_req.offset}, em[4:0]);
		check({wb_valid, cop_valid, exc_valid}, 3'b100 >> kind);
		check(kind == 0 ? wb_data : kind == 1 ? {32'h0, cop_data} : {61'h0, exc_code}, ed);
		if (kind == 0) check(wb_dest, dst);
		if (kind == 1) check(cop_sel, 2'b01);
		check(req_ready, 1'b1);
	endtask
	initial begin
		repeat (40000) @(posedge clock);
		n_errors++;
		finish_test();
	end
	initial begin
		int i;
		logic [2:0] va;
		logic [63:0] r1;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		axr(`CTRL_OFFSET, 32'h0000_0000, `RESP_OKAY);
		axr(`STATUS_OFFSET, 32'h0000_0000, `RESP_OKAY);
		axr(8'h40, 32'h0000_0000, `RESP_SLVERR);
		axw(8'h40, 32'hffff_ffff, `RESP_SLVERR);
		for (i = 0; i < 64; i++) begin
			va = i[2:0];
			delay <= i[3:0];
			axw(`CTRL_OFFSET, {28'h000_0000, i[4], i[5], i[1], i[3]}, `RESP_OKAY);
			ld(OP_LEFT, {13'h1fff, va}, 5'h01, OLD, 0, mrg(1'b1, va, i[3], i[4], OLD),
				{1'b1, va[1:0] ^ {2{i[3]}}, va[2] ^ i[5], 2'b00});
			ld(OP_RIGHT, {13'h1fff, va}, 5'h02, OLD, 0, mrg(1'b0, va, i[3], i[4], OLD),
				{1'b1, va[1:0] ^ {2{i[3]}}, va[2] ^ i[5], 2'b00});
		end
		axw(`CTRL_OFFSET, 32'h0000_0008, `RESP_OKAY);
		r1 = mrg(1'b1, 3'd1, 1'b0, 1'b1, OLD);
		ld(OP_LEFT, 16'hfff9, 5'h07, OLD, 0, r1, 6'b101000);
		ld(OP_RIGHT, 16'hfffa, 5'h07, ~OLD, 0, mrg(1'b0, 3'd2, 1'b0, 1'b1, r1), 6'b110000);
		axw(`CTRL_OFFSET, 32'h0000_0000, `RESP_OKAY);
		axw(`MASK_OFFSET, 32'h0000_0007, `RESP_OKAY);
		axw(`STATUS_OFFSET, 32'h0000_003f, `RESP_OKAY);
		// Last pass: an alignment fault from memory is reported as an address error
		for (i = 1; i < 6; i++) begin
			fault <= exc_code_type'(i[2:0]);
			ld(OP_LEFT, 16'hfff8, 5'h03, OLD, 2, i - i / 5, 6'b100000);
			repeat (2) @(posedge clock);
			check(irq, i < 4);
			axr(`STATUS_OFFSET, 32'h0000_0001 << (i - 1 - i / 5), `RESP_OKAY);
			axw(`STATUS_OFFSET, 32'h0000_003f, `RESP_OKAY);
			repeat (2) @(posedge clock);
			check(irq, 1'b0);
		end
		fault <= EXC_NONE;
		ld(OP_COP, 16'hfffc, 5'h00, OLD, 2, EXC_COP_UNUSABLE, 6'b000000);
		axw(`CTRL_OFFSET, 32'h0000_0024, `RESP_OKAY);
		ld(OP_COP, 16'hfffc, 5'h00, OLD, 1, {32'h0, DW[63:32]}, 6'b111011);
		ld(OP_COP, 16'hfffd, 5'h00, OLD, 2, EXC_ALIGN, 6'b000000);
		axr(`VIRTUAL_ADDRESS_OFFSET, 32'h0001_0005, `RESP_OKAY);
		finish_test();
	end
endmodule
